/* common/vip_pkg.sv */
// Function
// - All peripheral and trap requests are merged into one request to the processor core.
// - The primary vector table starts at program address 000004h and fetch addresses are computed from it.
// - The table holds 126 entries, eight trap vectors then 118 source vectors, one per source.
// - Each entry is a 24-bit handler address that is handed to the core when the request is taken.
// - Between pending sources of equal level the lower vector index wins, so vector zero beats all.
// - With the alternate select bit (bit 15 of control two) set, every vector comes from the alternate table.
// - The alternate table sits directly after the primary one with the same layout.
// - Reset bypasses the controller, clears alternate select, sets every priority to 100 and restarts the core at address 000000h.
// - A 3-bit priority of 111 is level seven down to 001 as level one, and 000 disables the source.
// - Priority control one holds the timer-two field at 14:12 and capture-compare-two at 10:8, both reset to 100.
// - Bits 15, 11 and 7:0 of priority control one ignore writes and read as zero.
package vip_pkg;

    localparam int N_TRAP = 8;
    localparam int N_SRC  = 118;
    localparam int N_VEC  = 126;
    localparam int N_MEM  = 2 * N_VEC;
    localparam int VA_W   = 24;
    localparam int IDX_W  = 7;
    localparam int MA_W   = 8;

    localparam logic [23:0] PRI_BASE   = 24'h000004;
    localparam logic [23:0] VEC_STEP   = 24'h000002;
    localparam logic [23:0] ALT_BASE   = 24'(PRI_BASE + VEC_STEP * N_VEC);
    localparam logic [23:0] RESET_ADDR = 24'h000000;

    // Register map, byte addresses
    localparam logic [11:0] CTRL2_OFF  = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] PCTL1_OFF  = 12'h008;
    localparam logic [1:0]  PRIO_RGN   = 2'h1;
    localparam logic [1:0]  VEC_RGN    = 2'h2;

    localparam int ALT_SEL_BIT    = 15;
    localparam int T2_PRIO_LSB    = 12;
    localparam int CCP2_PRIO_LSB  = 8;
    localparam logic [2:0] PRIO_RST = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam logic [3:0] TRAP_LVL = 4'h8;

    typedef enum logic [4:0] {
        S_IDLE    = 5'h01,
        S_FETCH   = 5'h02,
        S_WAIT    = 5'h04,
        S_PRESENT = 5'h08,
        S_ACK     = 5'h10
    } vip_state_t;

    function automatic logic [23:0] vip_fetch_addr(input logic alt, input logic [IDX_W-1:0] idx);
        logic [23:0] base;
        base = alt ? ALT_BASE : PRI_BASE;
        return 24'(base + VEC_STEP * idx);
    endfunction

    function automatic logic [MA_W-1:0] vip_mem_index(input logic alt, input logic [IDX_W-1:0] idx);
        return alt ? MA_W'(N_VEC + idx) : MA_W'(idx);
    endfunction

endpackage

/* design/vip_arbiter.sv */
`timescale 1ns/1ns
`default_nettype none
module vip_arbiter #(
    parameter int N_TRAP = 8,
    parameter int N_SRC  = 118,
    parameter int IDX_W  = 7
) (
    // Requests
    input  wire logic [N_TRAP-1:0]  trap_req,
    input  wire logic [N_SRC-1:0]   src_req,
    input  wire logic [3*N_SRC-1:0] prio_flat,
    // Winner
    output logic                    win_valid,
    output logic [IDX_W-1:0]        win_idx,
    output logic [3:0]              win_lvl
);

    // Ascending scan with strict compare keeps the lowest index on a tie
    always_comb
    begin
        win_valid = 1'b0;
        win_idx   = '0;
        win_lvl   = 4'h0;
        for (int t = 0; t < N_TRAP; t++)
        begin
            if (trap_req[t] && !win_valid)
            begin
                win_valid = 1'b1;
                win_idx   = IDX_W'(t);
                win_lvl   = vip_pkg::TRAP_LVL;
            end
        end
        for (int s = 0; s < N_SRC; s++)
        begin
            if (src_req[s] && prio_flat[3*s +: 3] != vip_pkg::PRIO_OFF && {1'b0, prio_flat[3*s +: 3]} > win_lvl)
            begin
                win_valid = 1'b1;
                win_idx   = IDX_W'(N_TRAP + s);
                win_lvl   = {1'b0, prio_flat[3*s +: 3]};
            end
        end
    end

endmodule
`default_nettype wire

/* design/vip_controller.sv */
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module vip_controller #(
    parameter int T2_SRC   = 7,
    parameter int CCP2_SRC = 6
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          nrst,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic                               pready,
    output logic [31:0]                        prdata,
    output logic                               pslverr,
    // Peripheral and trap requests
    input  wire logic [vip_pkg::N_TRAP-1:0]    trap_req,
    input  wire logic [vip_pkg::N_SRC-1:0]     src_req,
    output logic      [vip_pkg::N_TRAP-1:0]    trap_ack,
    output logic      [vip_pkg::N_SRC-1:0]     src_ack,
    // Core side
    output logic                               irq_req,
    output logic      [vip_pkg::VA_W-1:0]      irq_handler,
    output logic      [vip_pkg::VA_W-1:0]      irq_fetch_addr,
    output logic      [vip_pkg::IDX_W-1:0]     irq_index,
    input  wire logic                          cpu_ack,
    output logic                               core_restart,
    output logic      [vip_pkg::VA_W-1:0]      restart_addr
);

    vip_pkg::vip_state_t state;
    vip_pkg::vip_state_t next_state;

    logic                        alt_sel;
    logic                        cur_alt;
    logic [2:0]                  prio [vip_pkg::N_SRC];
    logic [3*vip_pkg::N_SRC-1:0] prio_flat;
    logic                        win_valid;
    logic [vip_pkg::IDX_W-1:0]   win_idx;
    logic [3:0]                  win_lvl;
    logic [vip_pkg::VA_W-1:0]    rd_data;

    // APB decode
    logic                        setup;
    logic                        wr;
    logic                        hit_ctrl;
    logic                        hit_stat;
    logic                        hit_pctl1;
    logic                        hit_prio;
    logic                        hit_vec;
    logic [6:0]                  prio_idx;
    logic [7:0]                  vec_widx;
    logic [15:0]                 pctl1_view;
    logic [31:0]                 rd_mux;

    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite;
    assign pready   = psel & penable;
    assign prio_idx = paddr[8:2];
    assign vec_widx = paddr[9:2];
    assign hit_ctrl = (paddr == vip_pkg::CTRL2_OFF);
    assign hit_stat = (paddr == vip_pkg::STATUS_OFF);
    assign hit_pctl1 = (paddr == vip_pkg::PCTL1_OFF);
    assign hit_prio = (paddr[11:10] == vip_pkg::PRIO_RGN) && (paddr[1:0] == 2'h0) && (paddr[9] == 1'b0)
                      && (prio_idx < 7'(vip_pkg::N_SRC));
    assign hit_vec  = (paddr[11:10] == vip_pkg::VEC_RGN) && (paddr[1:0] == 2'h0)
                      && (vec_widx < 8'(vip_pkg::N_MEM));

    // Unimplemented bits are simply never stored
    assign pctl1_view = {1'b0, prio[T2_SRC], 1'b0, prio[CCP2_SRC], 8'h00};

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
        begin
            rd_mux[vip_pkg::ALT_SEL_BIT] = alt_sel;
        end
        else if (hit_stat)
        begin
            rd_mux = {16'h0000, 7'h00, irq_req, 1'b0, irq_index};
        end
        else if (hit_pctl1)
        begin
            rd_mux = {16'h0000, pctl1_view};
        end
        else if (hit_prio)
        begin
            rd_mux = {29'h0000_0000, prio[prio_idx]};
        end
    end

    // Read data and error are formed in the setup cycle so both leave flops
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= rd_mux;
            pslverr <= ~(hit_ctrl | hit_stat | hit_pctl1 | hit_prio | hit_vec);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            alt_sel <= 1'b0;
        end
        else if (wr && hit_ctrl)
        begin
            alt_sel <= pwdata[vip_pkg::ALT_SEL_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < vip_pkg::N_SRC; i++)
            begin
                prio[i] <= vip_pkg::PRIO_RST;
            end
        end
        else if (wr && hit_pctl1)
        begin
            prio[T2_SRC]   <= pwdata[vip_pkg::T2_PRIO_LSB +: 3];
            prio[CCP2_SRC] <= pwdata[vip_pkg::CCP2_PRIO_LSB +: 3];
        end
        else if (wr && hit_prio)
        begin
            prio[prio_idx] <= pwdata[2:0];
        end
    end

    always_comb
    begin
        for (int i = 0; i < vip_pkg::N_SRC; i++)
        begin
            prio_flat[3*i +: 3] = prio[i];
        end
    end

    vip_arbiter #(
        .N_TRAP    (vip_pkg::N_TRAP),
        .N_SRC     (vip_pkg::N_SRC),
        .IDX_W     (vip_pkg::IDX_W)
    ) u_arb (
        .trap_req  (trap_req),
        .src_req   (src_req),
        .prio_flat (prio_flat),
        .win_valid (win_valid),
        .win_idx   (win_idx),
        .win_lvl   (win_lvl)
    );

    // Both tables share one array, alternate half above the primary
    vip_vec_mem #(
        .WIDTH (vip_pkg::VA_W),
        .DEPTH (vip_pkg::N_MEM),
        .AW    (vip_pkg::MA_W)
    ) u_mem (
        .sys_clk (sys_clk),
        .we      (wr & hit_vec),
        .waddr   (vec_widx),
        .wdata   (pwdata[vip_pkg::VA_W-1:0]),
        .re      (state == vip_pkg::S_FETCH),
        .raddr   (vip_pkg::vip_mem_index(cur_alt, irq_index)),
        .rdata   (rd_data)
    );

    // Winner is frozen once taken; a later higher request waits its turn
    always_comb
    begin
        next_state = state;
        unique case (state)
            vip_pkg::S_IDLE:    if (win_valid) next_state = vip_pkg::S_FETCH;
            vip_pkg::S_FETCH:   next_state = vip_pkg::S_WAIT;
            vip_pkg::S_WAIT:    next_state = vip_pkg::S_PRESENT;
            vip_pkg::S_PRESENT: if (cpu_ack) next_state = vip_pkg::S_ACK;
            vip_pkg::S_ACK:     next_state = vip_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state <= vip_pkg::S_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            irq_index      <= '0;
            cur_alt        <= 1'b0;
            irq_fetch_addr <= vip_pkg::RESET_ADDR;
        end
        else if (state == vip_pkg::S_IDLE && win_valid)
        begin
            irq_index      <= win_idx;
            cur_alt        <= alt_sel;
            irq_fetch_addr <= vip_pkg::vip_fetch_addr(alt_sel, win_idx);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            irq_handler <= vip_pkg::RESET_ADDR;
        end
        else if (state == vip_pkg::S_WAIT)
        begin
            irq_handler <= rd_data;
        end
    end

    // One request line to the core
    assign irq_req = (state == vip_pkg::S_PRESENT);

    // Ack pulse lets the source drop its level before the next scan
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            trap_ack <= '0;
            src_ack  <= '0;
        end
        else
        begin
            trap_ack <= '0;
            src_ack  <= '0;
            if (state == vip_pkg::S_PRESENT && cpu_ack)
            begin
                if (irq_index < 7'(vip_pkg::N_TRAP))
                begin
                    trap_ack[irq_index[2:0]] <= 1'b1;
                end
                else
                begin
                    src_ack[7'(irq_index - 7'(vip_pkg::N_TRAP))] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            core_restart <= 1'b1;
        end
        else
        begin
            core_restart <= 1'b0;
        end
    end

    assign restart_addr = vip_pkg::RESET_ADDR;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    req_after_fetch_a: assert property ((state == vip_pkg::S_FETCH) |-> ##2 irq_req)
        else $error("request not raised two cycles after fetch");
    handler_from_table_a: assert property ($rose(irq_req) |-> irq_handler == $past(rd_data))
        else $error("handler does not match table entry");
    fetch_addr_base_a: assert property (irq_req |-> irq_fetch_addr == (cur_alt ? vip_pkg::ALT_BASE
            : vip_pkg::PRI_BASE) + 24'(irq_index) * vip_pkg::VEC_STEP)
        else $error("fetch address off table base");
    alt_table_take_a: assert property ((state == vip_pkg::S_IDLE && win_valid && alt_sel) |=> cur_alt)
        else $error("alternate select not applied");
    ack_release_a: assert property ((irq_req && cpu_ack) |=> !irq_req && ((|src_ack) || (|trap_ack)))
        else $error("ack did not release request");
    trap_first_a: assert property ((|trap_req) |-> win_valid && win_lvl == vip_pkg::TRAP_LVL
            && win_idx < 7'(vip_pkg::N_TRAP))
        else $error("trap lost arbitration");
    disabled_src_a: assert property ((win_valid && win_idx >= 7'(vip_pkg::N_TRAP))
            |-> prio[7'(win_idx - 7'(vip_pkg::N_TRAP))] != vip_pkg::PRIO_OFF)
        else $error("disabled source won");
    pctl1_zero_bits_a: assert property ((setup && hit_pctl1) |=> (prdata & 32'hffff_88ff) == 32'h0000_0000)
        else $error("unimplemented priority control bits read nonzero");
    reset_restart_a: assert property ($rose(nrst) |-> core_restart && !irq_req && restart_addr == 24'h000000)
        else $error("reset did not restart at zero");
    single_req_a: assert property (irq_req |-> state == vip_pkg::S_PRESENT ##1 (irq_req || state == vip_pkg::S_ACK))
        else $error("request dropped without ack");

    alt_present_c: cover property (irq_req && cur_alt);
    trap_present_c: cover property (irq_req && irq_index < 7'(vip_pkg::N_TRAP));
    tie_break_c: cover property (win_valid && (src_req[0] && src_req[1]) && prio[0] == prio[1]);
    ack_done_c: cover property (state == vip_pkg::S_ACK ##1 win_valid);

endmodule
`default_nettype wire

/* design/vip_vec_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module vip_vec_mem #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 252,
    parameter int AW    = 8
) (
    // Clock
    input  wire logic             sys_clk,
    // Write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Read port
    input  wire logic             re,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // No reset on the array; software loads every entry it uses
    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (re)
        begin
            rdata <= mem[raddr];
        end
    end

endmodule
`default_nettype wire

/* tb/vip_controller_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module vip_controller_bench;
    logic sys_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq_req, cpu_ack, core_restart;
    logic [7:0] trap_req = 8'h00, trap_ack;
    logic [117:0] src_req = '0, src_ack;
    logic [23:0] irq_handler, irq_fetch_addr, restart_addr, got_handler;
    logic [6:0] irq_index, got_index;
    logic [3:0] ack_delay = 4'h0;
    int fails = 0;
    int check_count = 0;

    always #5 sys_clk = ~sys_clk;

    vip_controller i_vip_controller (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .trap_req(trap_req), .src_req(src_req), .trap_ack(trap_ack), .src_ack(src_ack), .irq_req(irq_req),
        .irq_handler(irq_handler), .irq_fetch_addr(irq_fetch_addr), .irq_index(irq_index), .cpu_ack(cpu_ack),
        .core_restart(core_restart), .restart_addr(restart_addr));
    vip_core_model i_vip_core_model (.sys_clk(sys_clk), .nrst(nrst), .irq_req(irq_req),
        .irq_handler(irq_handler), .irq_index(irq_index), .cpu_ack(cpu_ack), .ack_delay(ack_delay),
        .got_handler(got_handler), .got_index(got_index));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic give_up(input string what);
        fails++;
        $display("MISMATCH at %0t: timeout on %s", $time, what);
        tally_and_finish();
    endtask

    function automatic logic [31:0] vec_val(input int j);
        return {8'h00, 24'(24'h0a0000 + 24'(j) * 24'h000111)};
    endfunction

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            give_up("apb");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic        e;
        apb(1'b1, a, v, d, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err_exp);
        logic [31:0] d;
        logic        e;
        apb(1'b0, a, 32'h0, d, e);
        check(d, exp, "read data");
        check(e, err_exp, "slave error");
    endtask

    task automatic prio(input int k, input logic [2:0] p);
        wr(12'h400 + 12'(4 * k), {29'h0, p});
    endtask

    // Waits for the request, checks what is presented, then drops the source on its ack
    task automatic svc(input int idx, input logic alt);
        int n;
        int e;
        e = alt ? idx + 126 : idx;
        n = 0;
        while (irq_req !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (irq_req !== 1'b1)
            give_up("request");
        check(irq_index, idx, "vector index");
        check(irq_fetch_addr, (alt ? vip_pkg::ALT_BASE : vip_pkg::PRI_BASE) + 24'(2 * idx), "fetch");
        check(irq_handler, vec_val(e), "handler");
        n = 0;
        while ({src_ack, trap_ack} === '0 && n < 40)
        begin
            @(posedge sys_clk);
            n++;
        end
        if ({src_ack, trap_ack} === '0)
            give_up("ack");
        check(32'($countones({src_ack, trap_ack})), 1, "one ack");
        check(idx < 8 ? trap_ack[idx] : src_ack[idx-8], 1'b1, "ack source");
        if (idx < 8)
            trap_req[idx] <= 1'b0;
        else
            src_req[idx-8] <= 1'b0;
        @(posedge sys_clk);
        check({src_ack, trap_ack} === '0, 1'b1, "ack pulse");
        check(got_index, idx, "core index");
        check(got_handler, vec_val(e), "core handler");
    endtask

    task automatic t_regs;
        rd_chk(vip_pkg::PCTL1_OFF, 32'h4400, 1'b0);
        rd_chk(vip_pkg::CTRL2_OFF, 32'h0, 1'b0);
        wr(vip_pkg::PCTL1_OFF, 32'hffff);
        rd_chk(vip_pkg::PCTL1_OFF, 32'h7700, 1'b0);
        wr(vip_pkg::PCTL1_OFF, 32'h4400);
        rd_chk(12'h00c, 32'h0, 1'b1);
    endtask

    task automatic t_load;
        for (int j = 0; j < 252; j++)
            wr(12'h800 + 12'(4 * j), vec_val(j));
    endtask

    task automatic t_basic;
        ack_delay <= 4'h6;
        src_req[3] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_chk(vip_pkg::STATUS_OFF, 32'h0000_010b, 1'b0);
        svc(11, 1'b0);
        ack_delay <= 4'h0;
        src_req[1] <= 1'b1;
        src_req[0] <= 1'b1;
        svc(8, 1'b0);
        svc(9, 1'b0);
    endtask

    task automatic t_levels;
        prio(2, 3'h1);
        prio(9, 3'h7);
        src_req[2] <= 1'b1;
        src_req[9] <= 1'b1;
        svc(17, 1'b0);
        svc(10, 1'b0);
        prio(4, 3'h0);
        src_req[4] <= 1'b1;
        repeat (12)
        begin
            @(posedge sys_clk);
            check(irq_req, 1'b0, "disabled source");
        end
        prio(4, 3'h4);
        svc(12, 1'b0);
        prio(0, 3'h7);
        src_req[0] <= 1'b1;
        trap_req[6] <= 1'b1;
        svc(6, 1'b0);
        svc(8, 1'b0);
    endtask

    task automatic t_pctl1_map;
        wr(vip_pkg::PCTL1_OFF, 32'h6200);
        rd_chk(vip_pkg::PCTL1_OFF, 32'h6200, 1'b0);
        src_req[5] <= 1'b1;
        src_req[6] <= 1'b1;
        src_req[7] <= 1'b1;
        svc(15, 1'b0);
        svc(13, 1'b0);
        svc(14, 1'b0);
    endtask

    task automatic t_alt;
        wr(vip_pkg::CTRL2_OFF, 32'h8000);
        rd_chk(vip_pkg::CTRL2_OFF, 32'h8000, 1'b0);
        src_req[117] <= 1'b1;
        svc(125, 1'b1);
        trap_req[0] <= 1'b1;
        svc(0, 1'b1);
    endtask

    task automatic t_midreset;
        src_req[1] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(irq_req, 1'b1, "request before reset");
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(irq_req, 1'b0, "reset request");
        check({src_ack, trap_ack} === '0, 1'b1, "no ack in reset");
        check(core_restart, 1'b1, "restart");
        src_req <= '0;
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(core_restart, 1'b0, "restart done");
        rd_chk(vip_pkg::PCTL1_OFF, 32'h4400, 1'b0);
        rd_chk(vip_pkg::CTRL2_OFF, 32'h0, 1'b0);
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        check(core_restart, 1'b1, "restart in reset");
        check(restart_addr, 32'h0, "restart address");
        nrst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(core_restart, 1'b0, "restart released");
        t_regs();
        t_load();
        t_basic();
        t_levels();
        t_pctl1_map();
        t_alt();
        t_midreset();
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* tb/vip_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module vip_core_model (
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    // Controller side
    input  wire logic                      irq_req,
    input  wire logic [vip_pkg::VA_W-1:0]  irq_handler,
    input  wire logic [vip_pkg::IDX_W-1:0] irq_index,
    output logic                           cpu_ack,
    // Bench side
    input  wire logic [3:0]                ack_delay,
    output logic      [vip_pkg::VA_W-1:0]  got_handler,
    output logic      [vip_pkg::IDX_W-1:0] got_index
);
    logic [3:0] wait_cnt;

    // Slow acks keep the request standing for the bench to watch
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cpu_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (cpu_ack)
        begin
            cpu_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end
        else if (irq_req)
        begin
            if (wait_cnt >= ack_delay)
            begin
                cpu_ack     <= 1'b1;
                got_handler <= irq_handler;
                got_index   <= irq_index;
            end
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire
